/* File: src/plb_pkg.sv */
package plb_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 6;
   localparam int REQ_W = 3;
   localparam int EVT_W = 7;
   localparam int FIFO_DEPTH = 16;
   localparam int CB_INIT = 0;
   localparam int CB_CTL = 1;
   localparam int CB_DIEN = 2;
   localparam int CB_SIEN = 3;
   localparam int CB_EOB = 4;
   localparam int CB_TERM = 5;
   localparam int CB_FUNC = 6;
   localparam int CB_MPAR = 7;
   localparam int SEL_LSB = 2;
   localparam int CTL_LSB = 6;
   localparam int INI_LSB = 5;
   localparam int SEL_W = 14;
   localparam int CTL_W = 10;
   localparam int INI_W = 11;
   localparam int ST_ERR = 0;
   localparam int ST_LOST = 1;
   localparam int ST_PAR = 2;
   localparam int ST_INOP = 3;
   localparam int ST_MPAR = 4;
   localparam int ST_BUSY = 7;
   localparam int ST_RDY = 8;
   localparam int ST_EVT = 9;
   localparam int REQ_DATA = 0;
   localparam int REQ_SVC = 1;
   localparam int REQ_MEM = 2;
   localparam logic [DATA_W-1:0] PRIO_ONE = 16'h0001;
   localparam logic [ADDR_W-1:0] ZERO_ADDR = 6'h00;
   typedef enum {INS_NONE, INS_CMD, INS_STAT, INS_IDATA, INS_ODATA} plb_instr_t;
   typedef struct packed {
      logic masterClear;
      logic transferSync;
      logic [ADDR_W-1:0] deviceSelect;
      logic directionSelect;
      logic commandDataSelect;
      logic [REQ_W-1:0] update;
      logic linkClk;
      logic [DATA_W-1:0] data;
   } plb_cable_in_t;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic dataOe;
      logic [ADDR_W-1:0] sourceId;
      logic sourceIdOe;
      logic [REQ_W-1:0] request;
   } plb_cable_out_t;
endpackage : plb_pkg

/* File: src/plb_io_port.sv */
// Summary of operation
// RQ1 - data path is a 16-bit two-way bus, words flow both directions
// RQ2 - address bus: 6-bit controller select plus 2-bit transfer type
// RQ3 - during update periods data bus carries priority bits, not data
// RQ4 - compare device select lines with jumper address; match gives unit selected
// RQ5 - when selected, decode type lines into exactly one of four strobes
// RQ6 - each strobe qualified by transfer sync and lasts as long as it
// RQ7 - memory processor transfer sets zero address enable; then answer address zero
// RQ8 - output data pulse captures bus word into data register
// RQ9 - input data gate drives data word while sync gating lasts
// RQ10 - host holds sync at least one microsecond on input transfers
// RQ11 - input status gate drives status word while sync gating lasts
// RQ12 - status bit 0 is OR of error bits 1 to 6
// RQ13 - status bit 1 flags lost word: overflow in, underflow out; the code flags out only for a word sent to a full output queue in output mode
// RQ14 - bit 2 parity/checksum, bit 3 inoperable, bit 4 memory parity
// RQ15 - bits 7-15 events: busy, data ready, device-specific events
// RQ16 - channel issues terminate with bit 7 set on memory parity error
// RQ17 - bits 0,1 zero: select command loads bits 2-15 unless busy
// RQ18 - control command loads bits 6-15 when not busy
// RQ19 - initiate loads bits 5-15 when not busy and starts device
// RQ20 - every command load pulse also makes a status clear pulse
// RQ21 - cable carries master clear, clock, 3 request, 3 update, sync lines
// RQ22 - source ID names controller, or macro ROM entry for memory requests
// RQ23 - busy suppresses command load, freezing registers and status
// RQ24 - control with bits 4-6 zero is no-op, still applies interrupt enables
// RQ25 - bit 0 set decodes as transfer initiate command
// RQ26 - master clear returns command registers, flags, zero enable to clear
`timescale 1ns/100ps
`default_nettype none

module plb_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic clear,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr;
   logic [PW-1:0] rdPtr;
   logic [PW:0] count;
   logic push;
   logic pop;

   // output stage is a register, so the drain side sees flop outputs
   assign push = inValid && inReady;
   assign pop = (count != '0) && (!outValid || outReady);
   // the output stage holds a word too, so it counts toward the depth
   assign inReady = (count + (PW+1)'(outValid)) != (PW+1)'(DEPTH);

   always_ff @(posedge clk)
   begin
      if (clkEn && push)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else if (clkEn)
      begin
         if (clear)
         begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
         end
         else
         begin
            if (push)
            begin
               wrPtr <= PW'(wrPtr + 1'b1);
            end
            if (pop)
            begin
               rdPtr <= PW'(rdPtr + 1'b1);
            end
            count <= (PW+1)'(count + push - pop);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         outValid <= 1'b0;
         outData <= '0;
      end
      else if (clkEn)
      begin
         if (clear)
         begin
            outValid <= 1'b0;
         end
         else if (pop)
         begin
            outValid <= 1'b1;
            outData <= mem[rdPtr];
         end
         else if (outReady)
         begin
            outValid <= 1'b0;
         end
      end
   end
endmodule : plb_fifo

module plb_io_port (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire plb_pkg::plb_cable_in_t cableIn,
   output var plb_pkg::plb_cable_out_t cableOut,
   input wire logic [plb_pkg::ADDR_W-1:0] jumperAddr,
   input wire logic [3:0] priorityIdx,
   input wire logic [plb_pkg::ADDR_W-1:0] macroEntry,
   input wire logic [plb_pkg::REQ_W-1:0] userRequest,
   input wire logic devDone,
   input wire logic devParityErr,
   input wire logic devInoperable,
   input wire logic [plb_pkg::EVT_W-1:0] devEvents,
   input wire logic devInValid,
   input wire logic [plb_pkg::DATA_W-1:0] devInData,
   output logic devOutValid,
   input wire logic devOutReady,
   output logic [plb_pkg::DATA_W-1:0] devOutData,
   output logic unitSelected,
   output logic cmdStrobe,
   output logic inputStatusGate,
   output logic inputDataGate,
   output logic outputDataPulse,
   output logic statusClearPulse,
   output logic terminatePulse,
   output logic busy,
   output logic dataReady,
   output logic zeroAddressEnable,
   output logic dmpMode,
   output logic outputMode,
   output logic dataIntEnable,
   output logic serviceIntEnable,
   output logic [plb_pkg::DATA_W-1:0] dataReg,
   output logic [plb_pkg::SEL_W-1:0] selectCmd,
   output logic [plb_pkg::CTL_W-1:0] controlCmd,
   output logic [plb_pkg::INI_W-1:0] initiateCmd
);
   plb_pkg::plb_cable_in_t cableMeta;
   plb_pkg::plb_cable_in_t cableS;
   plb_pkg::plb_instr_t instr;
   logic [plb_pkg::ADDR_W-1:0] ownAddr;
   logic strapTaken;
   logic linkClkD;
   logic linkRise;
   logic mclr;
   logic next_unitSelected;
   logic [plb_pkg::DATA_W-1:0] w;
   logic cmdStart;
   logic odStart;
   logic idStart;
   logic loadOk;
   logic isSelect;
   logic isInit;
   logic isCtl;
   logic isNoop;
   logic isTerm;
   logic lostWord;
   logic devParity;
   logic memParity;
   logic lostEvt;
   logic [plb_pkg::DATA_W-1:0] statusWord;
   logic [plb_pkg::DATA_W-1:0] inData;
   logic inHold;
   logic fifoInReady;
   logic prioDrive;
   logic higherReq;

   function automatic plb_pkg::plb_instr_t decodeInstr(input logic sync, input logic sel,
                                                       input logic dir, input logic cds);
      if (!(sync && sel))
      begin
         return plb_pkg::INS_NONE;
      end
      case ({dir, cds})
         2'h3: return plb_pkg::INS_CMD;
         2'h2: return plb_pkg::INS_ODATA;
         2'h1: return plb_pkg::INS_STAT;
         2'h0: return plb_pkg::INS_IDATA;
         default: return plb_pkg::INS_NONE;
      endcase
   endfunction : decodeInstr

   function automatic logic [plb_pkg::DATA_W-1:0] prioOneHot(input logic [3:0] idx);
      return plb_pkg::DATA_W'(plb_pkg::PRIO_ONE << idx);
   endfunction : prioOneHot

   // every cable line crosses in through two flops before use
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cableMeta <= '0;
         cableS <= '0;
      end
      else if (clkEn)
      begin
         cableMeta <= cableIn;
         cableS <= cableMeta;
      end
   end

   // jumper address is a strap, caught once after reset release
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ownAddr <= '0;
         strapTaken <= 1'b0;
      end
      else if (clkEn && !strapTaken)
      begin
         ownAddr <= jumperAddr;
         strapTaken <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         linkClkD <= 1'b0;
      end
      else if (clkEn)
      begin
         linkClkD <= cableS.linkClk;
      end
   end

   assign linkRise = cableS.linkClk && !linkClkD;
   assign mclr = cableS.masterClear;
   assign w = cableS.data;
   // RQ2 RQ4 RQ7
   assign next_unitSelected = strapTaken && ((cableS.deviceSelect == ownAddr) ||
                              (zeroAddressEnable && cableS.deviceSelect == plb_pkg::ZERO_ADDR));
   assign instr = decodeInstr(cableS.transferSync, next_unitSelected,
                              cableS.directionSelect, cableS.commandDataSelect); // RQ5
   assign cmdStart = (instr == plb_pkg::INS_CMD) && !cmdStrobe;
   assign odStart = (instr == plb_pkg::INS_ODATA) && !outputDataPulse;
   assign idStart = (instr == plb_pkg::INS_IDATA) && !inputDataGate;
   assign isSelect = !w[plb_pkg::CB_INIT] && !w[plb_pkg::CB_CTL];
   assign isInit = w[plb_pkg::CB_INIT]; // RQ25
   assign isCtl = !w[plb_pkg::CB_INIT] && w[plb_pkg::CB_CTL] && !w[plb_pkg::CB_EOB] &&
                  !w[plb_pkg::CB_TERM] && w[plb_pkg::CB_FUNC]; // RQ18
   assign isNoop = !w[plb_pkg::CB_INIT] && w[plb_pkg::CB_CTL] && !w[plb_pkg::CB_EOB] &&
                   !w[plb_pkg::CB_TERM] && !w[plb_pkg::CB_FUNC]; // RQ24
   assign isTerm = !w[plb_pkg::CB_INIT] && w[plb_pkg::CB_CTL] && w[plb_pkg::CB_TERM];
   // busy masks the load pulse itself, not each register separately
   assign loadOk = cmdStart && !busy && !mclr; // RQ23

   // strobes are registered copies of the decode, so they track sync width
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         unitSelected <= 1'b0;
         cmdStrobe <= 1'b0;
         inputStatusGate <= 1'b0;
         inputDataGate <= 1'b0;
         outputDataPulse <= 1'b0;
      end
      else if (clkEn)
      begin
         unitSelected <= next_unitSelected; // RQ4
         cmdStrobe <= instr == plb_pkg::INS_CMD; // RQ6
         inputStatusGate <= instr == plb_pkg::INS_STAT; // RQ6
         inputDataGate <= instr == plb_pkg::INS_IDATA; // RQ6
         outputDataPulse <= instr == plb_pkg::INS_ODATA; // RQ6
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         selectCmd <= '0;
         controlCmd <= '0;
         initiateCmd <= '0;
      end
      else if (clkEn)
      begin
         if (mclr)
         begin
            selectCmd <= '0; // RQ26
            controlCmd <= '0;
            initiateCmd <= '0;
         end
         else if (loadOk)
         begin
            if (isSelect)
            begin
               selectCmd <= w[plb_pkg::SEL_LSB +: plb_pkg::SEL_W]; // RQ17
            end
            if (isCtl)
            begin
               controlCmd <= w[plb_pkg::CTL_LSB +: plb_pkg::CTL_W]; // RQ18
            end
            if (isInit)
            begin
               initiateCmd <= w[plb_pkg::INI_LSB +: plb_pkg::INI_W]; // RQ19
            end
         end
      end
   end

   // a no-op may change the enables even while busy
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dataIntEnable <= 1'b0;
         serviceIntEnable <= 1'b0;
      end
      else if (clkEn)
      begin
         if (mclr)
         begin
            dataIntEnable <= 1'b0;
            serviceIntEnable <= 1'b0;
         end
         else if (cmdStart && (isNoop || (!busy && (isInit || isCtl))))
         begin
            dataIntEnable <= w[plb_pkg::CB_DIEN]; // RQ24
            serviceIntEnable <= w[plb_pkg::CB_SIEN]; // RQ24
         end
      end
   end

   // terminate is honoured while busy, otherwise a busy device could never be stopped
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy <= 1'b0;
         dmpMode <= 1'b0;
         outputMode <= 1'b0;
         zeroAddressEnable <= 1'b0;
         terminatePulse <= 1'b0;
         statusClearPulse <= 1'b0;
      end
      else if (clkEn)
      begin
         statusClearPulse <= loadOk; // RQ20
         terminatePulse <= cmdStart && isTerm && !mclr;
         if (mclr)
         begin
            busy <= 1'b0; // RQ26
            dmpMode <= 1'b0;
            outputMode <= 1'b0;
            zeroAddressEnable <= 1'b0;
         end
         else if (loadOk && isInit)
         begin
            busy <= 1'b1; // RQ19
            dmpMode <= w[plb_pkg::CB_CTL];
            outputMode <= w[plb_pkg::CB_EOB];
            zeroAddressEnable <= w[plb_pkg::CB_CTL]; // RQ7
         end
         else
         begin
            if ((cmdStart && isTerm) || devDone)
            begin
               busy <= 1'b0;
            end
            if (!busy)
            begin
               zeroAddressEnable <= 1'b0;
            end
         end
      end
   end

   // input holding word from the device; a second word before pickup is lost
   assign lostEvt = (devInValid && inHold && !idStart) ||
                    (odStart && outputMode && !fifoInReady); // RQ13

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         inData <= '0;
         inHold <= 1'b0;
      end
      else if (clkEn)
      begin
         if (mclr)
         begin
            inHold <= 1'b0;
         end
         else if (devInValid && (!inHold || idStart))
         begin
            inData <= devInData;
            inHold <= 1'b1;
         end
         else if (idStart || (cmdStart && isTerm))
         begin
            inHold <= 1'b0;
         end
      end
   end

   // sticky errors: a set in the clearing cycle wins
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lostWord <= 1'b0;
         devParity <= 1'b0;
         memParity <= 1'b0;
      end
      else if (clkEn)
      begin
         if (mclr)
         begin
            lostWord <= 1'b0;
            devParity <= 1'b0;
            memParity <= 1'b0;
         end
         else
         begin
            lostWord <= lostEvt || (lostWord && !loadOk); // RQ13 RQ20
            devParity <= devParityErr || (devParity && !loadOk); // RQ14 RQ20
            memParity <= (cmdStart && isTerm && w[plb_pkg::CB_MPAR]) ||
                         (memParity && !loadOk); // RQ14
         end
      end
   end

   always_comb
   begin
      statusWord = '0;
      statusWord[plb_pkg::ST_LOST] = lostWord;
      statusWord[plb_pkg::ST_PAR] = devParity;
      statusWord[plb_pkg::ST_INOP] = devInoperable; // RQ14
      statusWord[plb_pkg::ST_MPAR] = memParity;
      statusWord[plb_pkg::ST_ERR] = |statusWord[plb_pkg::ST_MPAR+2:plb_pkg::ST_LOST]; // RQ12
      statusWord[plb_pkg::ST_BUSY] = busy; // RQ15
      statusWord[plb_pkg::ST_RDY] = dataReady;
      statusWord[plb_pkg::ST_EVT +: plb_pkg::EVT_W] = devEvents;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dataReg <= '0;
         dataReady <= 1'b0;
      end
      else if (clkEn)
      begin
         if (odStart)
         begin
            dataReg <= w; // RQ8
         end
         dataReady <= outputMode ? (busy && fifoInReady) : inHold;
      end
   end

   // output words queue toward the device; in output mode a full queue shows as not ready
   plb_fifo #(
      .WIDTH(plb_pkg::DATA_W),
      .DEPTH(plb_pkg::FIFO_DEPTH)
   ) outQueue (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .clear(mclr),
      .inValid(odStart && !mclr),
      .inReady(fifoInReady),
      .inData(w),
      .outValid(devOutValid),
      .outReady(devOutReady),
      .outData(devOutData)
   );

   // update window: drive own priority bit, withdraw source ID if outranked
   assign prioDrive = |(cableS.update & cableOut.request); // RQ3
   assign higherReq = |(cableS.data & plb_pkg::DATA_W'(prioOneHot(priorityIdx) - 1'b1));

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cableOut <= '0;
      end
      else if (clkEn)
      begin
         cableOut.dataOe <= (instr == plb_pkg::INS_IDATA) || (instr == plb_pkg::INS_STAT) ||
                            prioDrive; // RQ9 RQ11 RQ1
         if (instr == plb_pkg::INS_IDATA)
         begin
            cableOut.data <= inData; // RQ9
         end
         else if (instr == plb_pkg::INS_STAT)
         begin
            cableOut.data <= statusWord; // RQ11
         end
         else if (prioDrive)
         begin
            cableOut.data <= prioOneHot(priorityIdx); // RQ3
         end
         else
         begin
            cableOut.data <= '0;
         end
         cableOut.sourceIdOe <= prioDrive && !higherReq;
         if (cableS.update[plb_pkg::REQ_MEM] && cableOut.request[plb_pkg::REQ_MEM])
         begin
            cableOut.sourceId <= macroEntry; // RQ22
         end
         else
         begin
            cableOut.sourceId <= ownAddr; // RQ22
         end
         if (mclr)
         begin
            cableOut.request <= '0;
         end
         else if (linkRise)
         begin
            cableOut.request <= userRequest; // RQ21
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence loadSeq;
      clkEn && loadOk;
   endsequence
   sequence idGateSeq;
      clkEn && instr == plb_pkg::INS_IDATA;
   endsequence

   strobe_onehot_a: assert property ($onehot0({cmdStrobe, inputStatusGate, inputDataGate, outputDataPulse})) // RQ5
      else $error("more than one strobe");
   strobe_sync_a: assert property (clkEn && !cableS.transferSync |=> !(cmdStrobe || inputStatusGate || // RQ6
      inputDataGate || outputDataPulse)) else $error("strobe without sync");
   err_summary_a: assert property (clkEn && instr == plb_pkg::INS_STAT && (lostWord || memParity) // RQ12
      |=> cableOut.data[0]) else $error("error summary bit low");
   busy_block_a: assert property (clkEn && cmdStart && busy && !mclr |=> $stable(selectCmd) && // RQ23
      $stable(controlCmd) && $stable(initiateCmd)) else $error("command loaded while busy");
   clear_pulse_a: assert property (loadSeq |=> statusClearPulse && !$past(statusClearPulse, 2)) // RQ20
      else $error("no status clear pulse");
   init_busy_a: assert property (loadSeq ##0 isInit |=> busy && // RQ19
      initiateCmd == $past(w[plb_pkg::INI_LSB +: plb_pkg::INI_W])) else $error("initiate not taken");
   capture_word_a: assert property (clkEn && odStart |=> dataReg == $past(w)) // RQ8
      else $error("output word not captured");
   master_clear_a: assert property (clkEn && mclr |=> !busy && !zeroAddressEnable && // RQ26
      selectCmd == '0 && !lostWord) else $error("master clear incomplete");
   zero_resp_a: assert property (clkEn && zeroAddressEnable && strapTaken && // RQ7
      cableS.deviceSelect == plb_pkg::ZERO_ADDR |=> unitSelected) else $error("address zero ignored");
   input_gate_a: assert property (idGateSeq |=> cableOut.dataOe && cableOut.data == $past(inData)) // RQ9
      else $error("input word not driven");
   noop_keep_a: assert property (clkEn && cmdStart && isNoop && !mclr |=> $stable(controlCmd) && // RQ24
      dataIntEnable == $past(w[plb_pkg::CB_DIEN])) else $error("no-op misapplied");
endmodule : plb_io_port

`default_nettype wire

/* File: testbench/plb_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module plb_host_model (
   input wire logic clk,
   input wire plb_pkg::plb_cable_out_t cableOut,
   output var plb_pkg::plb_cable_in_t cableIn
);
   plb_pkg::plb_cable_in_t pins;
   logic hostOe;
   logic [15:0] hostData;
   logic [15:0] lastBus;
   initial
   begin
      pins = '0;
      hostOe = 1'b0;
      hostData = 16'h0000;
      lastBus = 16'h0000;
   end
   // cable clock runs free, it is a line of its own
   always #40 pins.linkClk = ~pins.linkClk;
   always @(posedge clk)
      if (cableOut.dataOe || hostOe)
         lastBus <= cableIn.data;
   // a released bus shows the inverse of its last value, so a missed drive never reads as good
   always_comb
   begin
      cableIn = pins;
      cableIn.data = cableOut.dataOe ? cableOut.data : (hostOe ? hostData : ~lastBus);
   end
   task automatic xfer(input logic [5:0] a, input logic d, input logic c, input logic [15:0] x,
                       output logic [15:0] r);
      @(negedge clk);
      pins.deviceSelect = a;
      pins.directionSelect = d;
      pins.commandDataSelect = c;
      hostData = x;
      hostOe = d;
      pins.transferSync = 1'b1;
      repeat (d ? 10 : 110) @(negedge clk);
      r = cableIn.data;
      pins.transferSync = 1'b0;
      repeat (6) @(negedge clk);
      hostOe = 1'b0;
   endtask : xfer
   task automatic ctl(input logic [2:0] u, input logic m);
      @(negedge clk);
      pins.update = u;
      pins.masterClear = m;
   endtask : ctl
endmodule : plb_host_model
`default_nettype wire

/* File: testbench/plb_io_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module plb_io_port_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [5:0] jumperAddr = 6'h2A;
   logic [3:0] priorityIdx = 4'h0;
   logic [2:0] userRequest = 3'h0;
   logic devDone = 1'b0;
   logic devInoperable = 1'b0;
   logic [6:0] devEvents = 7'h00;
   logic devInValid = 1'b0;
   logic [15:0] devInData = 16'h0000;
   logic devOutReady = 1'b0;
   logic devOutValid, statusClearPulse, busy, zeroAddressEnable, dataIntEnable;
   logic [15:0] devOutData, dataReg, rd, w, s0;
   logic [15:0] rs = 16'h0019;
   logic [13:0] selectCmd;
   logic [9:0] controlCmd;
   logic [10:0] initiateCmd;
   plb_pkg::plb_cable_in_t cableIn;
   plb_pkg::plb_cable_out_t cableOut;
   int error_cnt = 0;
   int checks_done = 0;
   int clrCnt = 0;
   int n;
   logic [15:0] q[$];
   always #5 clk = ~clk;
   plb_host_model i_plb_host_model (.clk(clk), .cableOut(cableOut), .cableIn(cableIn));
   plb_io_port i_plb_io_port (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .cableIn(cableIn),
      .cableOut(cableOut), .jumperAddr(jumperAddr), .priorityIdx(priorityIdx), .macroEntry(6'h05),
      .userRequest(userRequest), .devDone(devDone), .devParityErr(1'b0), .devInoperable(devInoperable),
      .devEvents(devEvents), .devInValid(devInValid), .devInData(devInData), .devOutValid(devOutValid),
      .devOutReady(devOutReady), .devOutData(devOutData), .unitSelected(), .cmdStrobe(),
      .inputStatusGate(), .inputDataGate(), .outputDataPulse(), .statusClearPulse(statusClearPulse),
      .terminatePulse(), .busy(busy), .dataReady(), .zeroAddressEnable(zeroAddressEnable), .dmpMode(),
      .outputMode(), .dataIntEnable(dataIntEnable), .serviceIntEnable(), .dataReg(dataReg),
      .selectCmd(selectCmd), .controlCmd(controlCmd), .initiateCmd(initiateCmd));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic io(input logic [5:0] a, input logic d, input logic c, input logic [15:0] x);
      i_plb_host_model.xfer(a, d, c, x, rd);
   endtask : io
   task automatic cmd(input logic [15:0] x);
      io(jumperAddr, 1'b1, 1'b1, x);
   endtask : cmd
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk)
   begin
      if (statusClearPulse === 1'b1)
         clrCnt++;
      if (devOutValid === 1'b1 && devOutReady === 1'b1 && q.size() > 0)
         chk(devOutData, q.pop_front());
   end
   // generous: the sequence needs well under 5000 cycles
   initial
   begin
      #200000;
      error_cnt++;
      tally_and_finish;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      devEvents = rs[6:0];
      repeat (4) @(negedge clk);
      rs = lfsr(rs);
      s0 = {rs[15:2], 2'b00};
      n = clrCnt;
      cmd(s0);
      chk(16'(selectCmd), 16'(s0[15:2]));
      chk(16'(clrCnt - n), 16'h0001);
      w = {rs[15:7], 3'b100, rs[3:2], 2'b10};
      cmd(w);
      chk(16'(controlCmd), 16'(w[15:6]));
      w = {rs[15:7], 3'b000, ~rs[3:2], 2'b10};
      cmd(w);
      chk(16'(controlCmd), {6'h00, rs[15:7], 1'b1});
      chk(16'(dataIntEnable), 16'(w[2]));
      $display("test commands done");
      w = {rs[15:5], 5'h13};
      cmd(w);
      chk(16'(initiateCmd), 16'(w[15:5]));
      chk(16'({busy, zeroAddressEnable}), 16'h0003);
      n = clrCnt;
      cmd(~s0 & 16'hFFFC);
      chk(16'(selectCmd), 16'(s0[15:2]));
      chk(16'(clrCnt - n), 16'h0000);
      io(6'h2B, 1'b1, 1'b0, 16'h5A5A);
      chk(dataReg, 16'h0000);
      for (int i = 0; i < 17; i++)
      begin
         rs = lfsr(rs);
         if (i < 16)
            q.push_back(rs);
         io(6'h00, 1'b1, 1'b0, rs);
         chk(dataReg, rs);
      end
      io(jumperAddr, 1'b0, 1'b1, 16'h0000);
      chk(rd, {devEvents, 9'h083});
      repeat (300)
      begin
         @(negedge clk);
         rs = lfsr(rs);
         devOutReady = rs[0];
      end
      chk(16'(q.size()), 16'h0000);
      $display("test fifo done");
      cmd(16'h00A2);
      chk(16'(busy), 16'h0000);
      io(jumperAddr, 1'b0, 1'b1, 16'h0000);
      chk(rd & 16'h0191, 16'h0011);
      cmd(16'h0001);
      chk(16'(busy), 16'h0001);
      @(negedge clk);
      devInData = rs;
      devInValid = 1'b1;
      @(negedge clk);
      devInValid = 1'b0;
      devInoperable = 1'b1;
      io(jumperAddr, 1'b0, 1'b0, 16'h0000);
      chk(rd, devInData);
      io(jumperAddr, 1'b0, 1'b1, 16'h0000);
      chk(rd & 16'h001F, 16'h0009);
      @(negedge clk);
      devDone = 1'b1;
      @(negedge clk);
      devDone = 1'b0;
      $display("test input done");
      priorityIdx = rs[3:0];
      userRequest = 3'b001;
      repeat (30) @(negedge clk);
      i_plb_host_model.ctl(3'b001, 1'b0);
      repeat (8) @(negedge clk);
      chk(cableIn.data, 16'h0001 << rs[3:0]);
      chk(16'({cableOut.sourceIdOe, cableOut.sourceId}), 16'({1'b1, jumperAddr}));
      i_plb_host_model.ctl(3'b000, 1'b1);
      repeat (8) @(negedge clk);
      chk(16'({busy, selectCmd}), 16'h0000);
      chk(16'(initiateCmd), 16'h0000);
      i_plb_host_model.ctl(3'b000, 1'b0);
      $display("test update and clear done");
      tally_and_finish;
   end
endmodule : plb_io_port_tb
`default_nettype wire
